// file: src/oob_fsm_regs.vh
// register map, field positions, reset values and timing figures of the host-emulation link bring-up block
`ifndef OOB_FSM_REGS_VH
`define OOB_FSM_REGS_VH

// register byte offsets
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04

// control fields
`define CTRL_ATTACH_BIT 0
`define CTRL_SAS_PATH_BIT 1
`define CTRL_RESET 32'h0000_0000

// status fields
`define STAT_STATE_LSB 0
`define STAT_RATE_LSB 16
`define STAT_REMOTE_WAKE_BIT 20
`define STAT_SYNC_BIT 21
`define STAT_LINK_UP_BIT 22

// bus encodings
`define HTRANS_NONSEQ 2'b10
`define HTRANS_SEQ 2'b11
`define HRESP_OKAY 1'b0
`define ZERO_WORD 32'h0000_0000

// link rates and counts
`define RATE_GEN1 2'b00
`define NON_ALIGN_RUN 2'h3
`define SYNC_RUN 2'h3

// timing figures
`define CLK_PERIOD_NS 8
`define COMSAS_TMO_NS 3500
`define D10_START_NS 533
`define ALIGN_TMO_US 880

`endif

// file: src/sata_host_emulation_oob_fsm.v
// link bring-up state machine: change reporting and host-emulation path toward an attached target
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "oob_fsm_regs.vh"
// Operation
// - signal loss while in sas_link_ready enters attach_change_report
// - three non-ALIGN primitives in align_sending may enter attach_change_report
// - attach_change_report returns to sas_link_ready when attach flag and signal both one
// - attach_change_report goes to reset when signal absent after change scheduled
// - no COMSAS within 3.5 us enters wake_transmit; leave once COMWAKE sent
// - wait_for_wake holds until an incoming COMWAKE, then wait_for_wake_end
// - end of received COMWAKE moves to await_align
// - await_align transmits D10.2 continuously at the slowest rate
// - D10.2 starts within 533 ns of the received COMWAKE ending
// - ALIGN seen at any supported rate moves to speed_adjust
// - no ALIGN within 880 us of entering await_align returns to reset
// - speed_adjust takes the received rate, then enters align_sending
// - align_sending sends ALIGN until three consecutive non-ALIGN primitives arrive
// - sata_change_report requests CHANGE, then enters sata_link_ready once scheduled
// - sata_link_ready holds link up and sends link dwords; COMINIT resets
// - in attach mode, slumber or partial requests enter the power-save states
// - power-save states record whether a COMWAKE arrived from the far end
// - COMWAKE in slumber leads to wait_for_wake_end once the phy recovered
// - slumber request dropped with no COMWAKE seen leaves for wake_transmit, sending COMWAKE
// - partial state exits on COMWAKE or on its request dropping
// - dword synchronizer needs an error-free run before declaring sync
// - without dword sync, received primitives are withheld from align_sending; await_align takes ALIGN regardless of sync

module sata_host_emulation_oob_fsm #(
    parameter integer COMSAS_TMO_CYC = `COMSAS_TMO_NS / `CLK_PERIOD_NS,
    parameter integer ALIGN_TMO_CYC = `ALIGN_TMO_US * 1000 / `CLK_PERIOD_NS
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire rx_signal_present,
    input wire sas_negotiation_done,
    input wire comsas_awaiting,
    input wire comsas_detected,
    input wire comwake_tx_done,
    input wire comwake_detected,
    input wire comwake_ended,
    input wire align_detected,
    input wire [1:0] align_rate,
    input wire rate_adjusted,
    input wire non_align_prim,
    input wire rx_dword_valid,
    input wire rx_dword_invalid,
    input wire cominit_detected,
    input wire change_scheduled,
    input wire phy_recovered,
    input wire link_slumber_request,
    input wire link_partial_request,
    output reg link_up_to_link_layer,
    output reg tx_comwake,
    output reg tx_d10_2,
    output reg tx_align,
    output reg tx_link_dwords,
    output reg [1:0] tx_rate,
    output reg change_request,
    output reg remote_wake,
    output reg dword_sync,
    output reg [12:0] phy_state
);

    // longest wait for D10.2 after COMWAKE ends; the machine starts it on the very next edge
    localparam integer D10_START_CYC = `D10_START_NS / `CLK_PERIOD_NS;

    // **********************************************************************
    // state encoding
    // **********************************************************************
    localparam [12:0] S_RESET = 13'h0001;
    localparam [12:0] S_SAS_READY = 13'h0002;
    localparam [12:0] S_ATTACH_CHG = 13'h0004;
    localparam [12:0] S_WAKE_TX = 13'h0008;
    localparam [12:0] S_WAIT_WAKE = 13'h0010;
    localparam [12:0] S_WAIT_WAKE_END = 13'h0020;
    localparam [12:0] S_AWAIT_ALIGN = 13'h0040;
    localparam [12:0] S_SPEED_ADJ = 13'h0080;
    localparam [12:0] S_ALIGN_SEND = 13'h0100;
    localparam [12:0] S_SATA_CHG = 13'h0200;
    localparam [12:0] S_SATA_READY = 13'h0400;
    localparam [12:0] S_DEEP_PS = 13'h0800;
    localparam [12:0] S_LIGHT_PS = 13'h1000;

    // **********************************************************************
    // bus slave
    // **********************************************************************
    reg [31:0] ctrl_r;
    reg wr_pend_r;
    reg [7:0] wr_addr_r;
    wire [7:0] addr_lo;
    wire addr_phase;
    wire sata_attach_flag;
    wire sas_path_change;

    assign addr_lo = haddr[7:0];
    assign addr_phase = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
    assign sata_attach_flag = ctrl_r[`CTRL_ATTACH_BIT];
    assign sas_path_change = ctrl_r[`CTRL_SAS_PATH_BIT];

    function [31:0] read_mux;
        input [7:0] a;
        begin
            case (a)
                `CTRL_OFFSET: read_mux = ctrl_r;
                `STATUS_OFFSET: read_mux = {9'h000, link_up_to_link_layer, dword_sync, remote_wake,
                                            2'b00, tx_rate, 3'b000, phy_state};
                default: read_mux = `ZERO_WORD;
            endcase
        end
    endfunction

    // zero wait states: read data is captured in the address phase and stands through the data phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= `ZERO_WORD;
            hreadyout <= 1'b0;
            hresp <= `HRESP_OKAY;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            ctrl_r <= `CTRL_RESET;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= `HRESP_OKAY;
            wr_pend_r <= addr_phase && hwrite;
            wr_addr_r <= addr_lo;
            if (addr_phase && !hwrite)
                hrdata <= read_mux(addr_lo);
            if (wr_pend_r && wr_addr_r == `CTRL_OFFSET)
                ctrl_r <= {30'h0000_0000, hwdata[1:0]};
        end
    end

    // **********************************************************************
    // dword synchronizer
    // **********************************************************************
    reg [1:0] sync_run_r;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync_run_r <= 2'b00;
            dword_sync <= 1'b0;
        end
        else if (!rx_signal_present || rx_dword_invalid)
        begin
            sync_run_r <= 2'b00;
            dword_sync <= 1'b0;
        end
        else if (rx_dword_valid && !dword_sync)
        begin
            sync_run_r <= sync_run_r + 2'b01;
            dword_sync <= (sync_run_r + 2'b01) == `SYNC_RUN;
        end
    end

    // primitives reach the align_sending counter only while in sync; await_align uses align_detected ungated
    wire non_align_ok;
    wire align_ok;

    assign non_align_ok = non_align_prim && dword_sync;
    assign align_ok = align_detected && dword_sync;

    // **********************************************************************
    // timers and counters
    // **********************************************************************
    reg [31:0] tmo_cnt_r;
    reg [1:0] non_align_cnt_r;
    reg state_entry_r;
    wire comsas_expired;
    wire align_expired;
    wire third_non_align;

    assign comsas_expired = comsas_awaiting && !comsas_detected && tmo_cnt_r >= COMSAS_TMO_CYC - 1;
    assign align_expired = tmo_cnt_r >= ALIGN_TMO_CYC - 1;
    assign third_non_align = non_align_ok && non_align_cnt_r == `NON_ALIGN_RUN - 2'h1;

    // **********************************************************************
    // state machine
    // **********************************************************************
    reg [12:0] state_nxt;

    always @*
    begin
        state_nxt = phy_state;
        case (phy_state)
            S_RESET:
                if (sas_negotiation_done)
                    state_nxt = S_SAS_READY;
                else if (comsas_expired)
                    state_nxt = S_WAKE_TX;
            S_SAS_READY:
                if (cominit_detected)
                    state_nxt = S_RESET;
                else if (!rx_signal_present)
                    state_nxt = S_ATTACH_CHG;
            S_ATTACH_CHG:
                if (change_scheduled)
                begin
                    if (!rx_signal_present)
                        state_nxt = S_RESET;
                    else if (sata_attach_flag)
                        state_nxt = S_SAS_READY;
                    else
                        state_nxt = S_RESET;
                end
            S_WAKE_TX:
                if (comwake_tx_done)
                    state_nxt = S_WAIT_WAKE;
            S_WAIT_WAKE:
                if (comwake_detected)
                    state_nxt = S_WAIT_WAKE_END;
            S_WAIT_WAKE_END:
                if (comwake_ended)
                    state_nxt = S_AWAIT_ALIGN;
            S_AWAIT_ALIGN:
                if (align_detected)
                    state_nxt = S_SPEED_ADJ;
                else if (align_expired)
                    state_nxt = S_RESET;
            S_SPEED_ADJ:
                if (rate_adjusted && !state_entry_r)
                    state_nxt = S_ALIGN_SEND;
            S_ALIGN_SEND:
                if (third_non_align)
                    state_nxt = sas_path_change ? S_ATTACH_CHG : S_SATA_CHG;
            S_SATA_CHG:
                if (change_scheduled)
                    state_nxt = S_SATA_READY;
            S_SATA_READY:
                if (cominit_detected)
                    state_nxt = S_RESET;
                else if (sata_attach_flag && link_slumber_request)
                    state_nxt = S_DEEP_PS;
                else if (sata_attach_flag && link_partial_request)
                    state_nxt = S_LIGHT_PS;
            S_DEEP_PS:
                if ((remote_wake || comwake_detected) && phy_recovered)
                    state_nxt = S_WAIT_WAKE_END;
                else if (!remote_wake && !comwake_detected && !link_slumber_request)
                    state_nxt = S_WAKE_TX;
            S_LIGHT_PS:
                if (comwake_detected)
                    state_nxt = S_WAIT_WAKE_END;
                else if (!link_partial_request)
                    state_nxt = S_WAKE_TX;
            default:
                state_nxt = S_RESET;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phy_state <= S_RESET;
            state_entry_r <= 1'b1;
            tmo_cnt_r <= 32'h0000_0000;
            non_align_cnt_r <= 2'b00;
            remote_wake <= 1'b0;
            tx_rate <= `RATE_GEN1;
            link_up_to_link_layer <= 1'b0;
            tx_comwake <= 1'b0;
            tx_d10_2 <= 1'b0;
            tx_align <= 1'b0;
            tx_link_dwords <= 1'b0;
            change_request <= 1'b0;
        end
        else
        begin
            phy_state <= state_nxt;
            state_entry_r <= state_nxt != phy_state;
            // one counter serves the COMSAS wait in reset and the ALIGN wait; restarted on each state change
            if (state_nxt != phy_state || (phy_state == S_RESET && !comsas_awaiting))
                tmo_cnt_r <= 32'h0000_0000;
            else if (phy_state == S_RESET || phy_state == S_AWAIT_ALIGN)
                tmo_cnt_r <= tmo_cnt_r + 32'h0000_0001;
            if (phy_state != S_ALIGN_SEND || align_ok)
                non_align_cnt_r <= 2'b00;
            else if (non_align_ok)
                non_align_cnt_r <= non_align_cnt_r + 2'b01;
            if (state_nxt == S_DEEP_PS && phy_state != S_DEEP_PS)
                remote_wake <= 1'b0;
            else if (state_nxt == S_LIGHT_PS && phy_state != S_LIGHT_PS)
                remote_wake <= 1'b0;
            else if ((phy_state == S_DEEP_PS || phy_state == S_LIGHT_PS) && comwake_detected)
                remote_wake <= 1'b1;
            if (state_nxt == S_AWAIT_ALIGN)
                tx_rate <= `RATE_GEN1;
            else if (phy_state == S_SPEED_ADJ && state_entry_r)
                tx_rate <= align_rate;
            // drive flags follow the next state so they change with the state itself
            tx_comwake <= state_nxt == S_WAKE_TX;
            tx_d10_2 <= state_nxt == S_AWAIT_ALIGN;
            tx_align <= state_nxt == S_ALIGN_SEND;
            tx_link_dwords <= state_nxt == S_SATA_READY || state_nxt == S_SAS_READY;
            link_up_to_link_layer <= state_nxt == S_SATA_READY || state_nxt == S_SAS_READY;
            change_request <= state_nxt == S_SATA_CHG || state_nxt == S_ATTACH_CHG;
        end
    end

endmodule // sata_host_emulation_oob_fsm

// file: tb/oob_fsm_chk.sv
// concurrent checks on the link bring-up state machine ports
`timescale 1ns/10ps
module oob_fsm_chk #(
    parameter integer ALIGN_TMO_CYC = 50
) (
    input wire hclk,
    input wire hresetn,
    input wire rx_signal_present,
    input wire comwake_tx_done,
    input wire comwake_detected,
    input wire comwake_ended,
    input wire align_detected,
    input wire [1:0] align_rate,
    input wire cominit_detected,
    input wire change_scheduled,
    input wire phy_recovered,
    input wire [12:0] phy_state,
    input wire tx_comwake,
    input wire tx_d10_2,
    input wire [1:0] tx_rate,
    input wire link_up_to_link_layer,
    input wire remote_wake
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    reg [31:0] await_cnt_r;
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            await_cnt_r <= 32'h0;
        else
            await_cnt_r <= (phy_state == 13'h0040) ? await_cnt_r + 1 : 32'h0;
    // ****************************************
    // state moves
    // ****************************************
    a_unplug_change: assert property (phy_state == 13'h0002 && !rx_signal_present |=> phy_state == 13'h0004)
        else $error("unplug not reported");
    a_change_drop: assert property (phy_state == 13'h0004 && change_scheduled && !rx_signal_present
        |=> phy_state == 13'h0001)
        else $error("change report did not reset");
    a_wake_hold: assert property (phy_state == 13'h0008 && !comwake_tx_done |=> phy_state == 13'h0008 && tx_comwake)
        else $error("wake transmit left early");
    a_wake_wait: assert property (phy_state == 13'h0010 && comwake_detected |=> phy_state == 13'h0020)
        else $error("incoming wake missed");
    a_wake_end: assert property (phy_state == 13'h0020 && comwake_ended
        |=> phy_state == 13'h0040 && tx_d10_2 && tx_rate == 2'b00)
        else $error("pattern not sent after wake end");
    a_align_seen: assert property (phy_state == 13'h0040 && align_detected
        |=> phy_state == 13'h0080 ##1 tx_rate == align_rate)
        else $error("rate not adopted");
    a_align_limit: assert property (await_cnt_r <= ALIGN_TMO_CYC + 1)
        else $error("await align outlived its limit");
    a_ready_flag: assert property (phy_state == 13'h0400 |-> link_up_to_link_layer)
        else $error("ready flag low in ready");
    a_cominit_reset: assert property (phy_state == 13'h0400 && cominit_detected |=> phy_state == 13'h0001)
        else $error("cominit ignored");
    a_slumber_wait: assert property (phy_state == 13'h0800 && remote_wake && !phy_recovered
        |=> phy_state == 13'h0800)
        else $error("slumber left before recovery");
endmodule // oob_fsm_chk
bind sata_host_emulation_oob_fsm oob_fsm_chk #(.ALIGN_TMO_CYC(ALIGN_TMO_CYC)) u_chk (.*);

// file: tb/sata_host_emulation_oob_fsm_tb.sv
// self-checking bench for the link bring-up state machine
`timescale 1ns/10ps
module sata_host_emulation_oob_fsm_tb;
    reg hclk, hresetn, hsel, hwrite, sas_negotiation_done, comsas_awaiting, comsas_detected, non_align_prim;
    reg rx_signal_present, rx_dword_valid, rx_dword_invalid, cominit_detected, change_scheduled, phy_recovered;
    reg link_slumber_request, link_partial_request, send_wake, send_align;
    reg [31:0] haddr, hwdata, rd;
    reg [1:0] htrans;
    reg [2:0] hsize;
    wire hready, hreadyout, hresp, comwake_tx_done, comwake_detected, comwake_ended, align_detected, rate_adjusted;
    wire link_up_to_link_layer, tx_comwake, tx_d10_2, tx_align, tx_link_dwords, change_request, remote_wake, dword_sync;
    wire [1:0] align_rate, tx_rate;
    wire [31:0] hrdata;
    wire [12:0] phy_state;
    integer error_cnt = 0, total_checks = 0, cyc = 0;
    assign hready = hreadyout;
    sata_host_emulation_oob_fsm #(.COMSAS_TMO_CYC(8), .ALIGN_TMO_CYC(50)) u_dut (.*);
    sata_target_model #(.DLY(3)) u_far (.*);
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task chk(input [31:0] got, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task ahb(input w, input [31:0] a, input [31:0] wd);
    begin
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        // select stays up with htrans idle so a following call never drives hsel twice in one step
        rd = hrdata;
    end
    endtask
    task wait_state(input [12:0] code);
        integer n;
    begin
        n = 0;
        while (phy_state !== code && n < 200)
        begin
            @(posedge hclk);
            n = n + 1;
        end
        chk({19'h0, phy_state}, {19'h0, code});
    end
    endtask
    task pulse3(input integer kind);
    begin
        repeat (3)
        begin
            rx_dword_valid <= (kind == 0);
            non_align_prim <= (kind == 1);
            @(posedge hclk);
            {rx_dword_valid, non_align_prim} <= 2'b00;
            @(posedge hclk);
        end
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
    begin
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
    end
    endtask
    task t_unplug;
    begin
        sas_negotiation_done <= 1'b1;
        @(posedge hclk);
        sas_negotiation_done <= 1'b0;
        wait_state(13'h0002);
        rx_signal_present <= 1'b0;
        wait_state(13'h0004);
        change_scheduled <= 1'b1;
        wait_state(13'h0001);
        change_scheduled <= 1'b0;
        rx_signal_present <= 1'b1;
    end
    endtask
    task t_attach;
    begin
        sas_negotiation_done <= 1'b1;
        @(posedge hclk);
        sas_negotiation_done <= 1'b0;
        wait_state(13'h0002);
        rx_signal_present <= 1'b0;
        wait_state(13'h0004);
        rx_signal_present <= 1'b1;
        change_scheduled <= 1'b1;
        wait_state(13'h0002);
        change_scheduled <= 1'b0;
        ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
        rx_signal_present <= 1'b0;
        wait_state(13'h0004);
        rx_signal_present <= 1'b1;
        change_scheduled <= 1'b1;
        wait_state(13'h0001);
        change_scheduled <= 1'b0;
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
    end
    endtask
    task t_to_wake;
    begin
        comsas_awaiting <= 1'b1;
        wait_state(13'h0008);
        comsas_awaiting <= 1'b0;
        chk({31'h0, tx_comwake}, 32'h1);
    end
    endtask
    task t_to_ready;
    begin
        wait_state(13'h0040);
        chk({29'h0, tx_d10_2, tx_rate}, 32'h4);
        send_align <= 1'b1;
        wait_state(13'h0100);
        send_align <= 1'b0;
        chk({29'h0, tx_align, tx_rate}, 32'h5);
        pulse3(0);
        chk({31'h0, dword_sync}, 32'h1);
        pulse3(1);
        wait_state(13'h0200);
        chk({31'h0, change_request}, 32'h1);
        change_scheduled <= 1'b1;
        wait_state(13'h0400);
        change_scheduled <= 1'b0;
        chk({30'h0, link_up_to_link_layer, tx_link_dwords}, 32'h3);
    end
    endtask
    task t_power;
    begin
        link_slumber_request <= 1'b1;
        wait_state(13'h0800);
        link_slumber_request <= 1'b0;
        wait_state(13'h0008);
        t_to_ready;
        link_slumber_request <= 1'b1;
        wait_state(13'h0800);
        send_wake <= 1'b1;
        @(posedge hclk);
        send_wake <= 1'b0;
        repeat (8) @(posedge hclk);
        chk({18'h0, remote_wake, phy_state}, 32'h2800);
        phy_recovered <= 1'b1;
        wait_state(13'h0040);
        link_slumber_request <= 1'b0;
        t_to_ready;
        cominit_detected <= 1'b1;
        wait_state(13'h0001);
        cominit_detected <= 1'b0;
        t_to_wake;
        t_to_ready;
        link_partial_request <= 1'b1;
        wait_state(13'h1000);
        link_partial_request <= 1'b0;
        wait_state(13'h0008);
        wait_state(13'h0040);
        repeat (45) @(posedge hclk);
        chk({19'h0, phy_state}, 32'h0040);
        wait_state(13'h0001);
    end
    endtask
    always @(posedge hclk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt = error_cnt + 1;
            end_of_test;
        end
    end
    initial
    begin
        {hresetn, hsel, hwrite, sas_negotiation_done, comsas_awaiting, comsas_detected, non_align_prim} = 7'h00;
        {rx_dword_valid, rx_dword_invalid, cominit_detected, change_scheduled, phy_recovered} = 5'h00;
        {link_slumber_request, link_partial_request, send_wake, send_align} = 4'h0;
        rx_signal_present = 1'b1;
        {haddr, hwdata} = 64'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs;
        t_unplug;
        t_attach;
        t_to_wake;
        t_to_ready;
        t_power;
        end_of_test;
    end
endmodule // sata_host_emulation_oob_fsm_tb

// file: tb/sata_target_model.sv
// behavioural attached target answering the wake and speed exchange
`timescale 1ns/10ps
module sata_target_model #(
    parameter integer DLY = 3
) (
    input wire hclk,
    input wire hresetn,
    input wire tx_comwake,
    input wire tx_d10_2,
    input wire send_wake,
    input wire send_align,
    output reg comwake_tx_done,
    output reg comwake_detected,
    output reg comwake_ended,
    output reg align_detected,
    output reg [1:0] align_rate,
    output reg rate_adjusted
);
    reg [3:0] wait_r;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wait_r <= 4'h0;
            {comwake_tx_done, comwake_detected, comwake_ended, align_detected, rate_adjusted} <= 5'h00;
            align_rate <= 2'b01;
        end
        else
        begin
            comwake_tx_done <= tx_comwake & ~comwake_tx_done;
            // the far end answers once our own wake burst is over, or when send_wake asks it to wake first
            wait_r <= (comwake_tx_done | send_wake) ? DLY : wait_r - (wait_r != 4'h0);
            comwake_detected <= (wait_r == 4'h1);
            comwake_ended <= comwake_detected | (comwake_ended & (wait_r == 4'h0));
            align_detected <= send_align & tx_d10_2;
            // level so the speed adjust sees it past its entry cycle
            rate_adjusted <= (rate_adjusted | align_detected) & ~tx_d10_2;
        end
    end
endmodule // sata_target_model
